// File: src/hif_pkg.sv
// Package: register map, field positions, reset values and carriers of the host configuration bank.
package hif_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_INTERRUPT_MASK   = 8'h5C;
	localparam logic [7:0] ADDR_BYTE_ORDER_PROBE = 8'h64;
	localparam logic [7:0] ADDR_FIFO_THRESHOLDS  = 8'h68;
	localparam logic [7:0] ADDR_RECEIVE_CONFIG   = 8'h6C;

	// ------------------------------------------------------------
	// Reset values and fixed patterns
	// ------------------------------------------------------------
	localparam logic [31:0] BYTE_ORDER_PATTERN  = 32'h87654321;
	localparam logic [31:0] INTERRUPT_MASK_RST  = 32'h00000000;
	localparam logic [31:0] INTERRUPT_MASK_WMSK = 32'h83BFEFFF;
	localparam logic [31:0] FIFO_THRESHOLDS_RST = 32'h48000000;
	localparam logic [31:0] RECEIVE_CONFIG_WMSK = 32'hCFFF9F00;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TX_SPACE_LSB      = 24;
	localparam int TX_STAT_LVL_LSB   = 16;
	localparam int RX_SPACE_LSB      = 8;
	localparam int RX_STAT_LVL_LSB   = 0;
	localparam int ALIGN_LSB         = 30;
	localparam int COUNTDOWN_LSB     = 16;
	localparam int FLUSH_BIT         = 15;
	localparam int OFFSET_LSB        = 8;
	localparam int SRC_TX_SPACE      = 9;
	localparam int SRC_TX_STAT_LVL   = 7;
	localparam int SRC_RX_SPACE      = 5;
	localparam int SRC_RX_STAT_LVL   = 3;
	localparam int SRC_RX_DMA_DONE   = 20;

	// ------------------------------------------------------------
	// End alignment codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		HIF_ALIGN_4  = 2'h0,
		HIF_ALIGN_16 = 2'h1,
		HIF_ALIGN_32 = 2'h2,
		HIF_ALIGN_RS = 2'h3
	} hif_align_e;

	// Host register access, one word per strobe.
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} hif_bus_s;

	// FIFO occupancy reported by the FIFO controllers.
	typedef struct packed {
		logic [7:0] tx_space;
		logic [7:0] tx_stat_used;
		logic [7:0] rx_space;
		logic [7:0] rx_stat_used;
	} hif_levels_s;

	// Complete state of the bank.
	typedef struct packed {
		logic [31:0] mask;
		logic [31:0] status;
		logic [31:0] thresholds;
		logic [1:0]  align;
		logic [11:0] countdown;
		logic        flush;
		logic [4:0]  offset;
		logic [2:0]  word_offset;
		logic [31:0] rdata;
		logic        irq;
	} hif_state_s;

endpackage : hif_pkg

// File: src/hif_regs.sv
// Module: host interrupt mask, FIFO thresholds and receive configuration bank.
`timescale 1ns/1ps
`default_nettype none

module hif_regs (
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                resetn,
	// Host register port
	input  wire hif_pkg::hif_bus_s   bus,
	output logic [31:0]              rdata,
	output logic                     irq,
	// Interrupt sources and FIFO levels
	input  wire logic [31:0]         src_events,
	input  wire hif_pkg::hif_levels_s levels,
	// Receive datapath
	input  wire logic                rx_word_read,
	input  wire logic                rx_packet_end,
	output logic                     rx_flush,
	output logic [1:0]               rx_align,
	output logic [4:0]               rx_offset,
	output logic [2:0]               rx_pad_words,
	// Status view for the status register elsewhere
	output logic [31:0]              status
);

	hif_pkg::hif_state_s st;
	hif_pkg::hif_state_s next_st;
	logic [31:0]         events;
	logic [31:0]         wsel;
	logic                cnt_done;
	logic [2:0]          pad;

	// ------------------------------------------------------------
	// FIFO level and countdown events
	// ------------------------------------------------------------
	// Level events are plain comparisons; they re-fire each cycle while true,
	// which is harmless since the status bit is sticky anyway.
	always_comb begin
		events = src_events;
		events[hif_pkg::SRC_TX_SPACE] = src_events[hif_pkg::SRC_TX_SPACE] |
			(levels.tx_space >
			 st.thresholds[hif_pkg::TX_SPACE_LSB +: 8]);
		events[hif_pkg::SRC_TX_STAT_LVL] =
			src_events[hif_pkg::SRC_TX_STAT_LVL] |
			(levels.tx_stat_used >
			 st.thresholds[hif_pkg::TX_STAT_LVL_LSB +: 8]);
		events[hif_pkg::SRC_RX_SPACE] = src_events[hif_pkg::SRC_RX_SPACE] |
			(levels.rx_space <
			 st.thresholds[hif_pkg::RX_SPACE_LSB +: 8]);
		events[hif_pkg::SRC_RX_STAT_LVL] =
			src_events[hif_pkg::SRC_RX_STAT_LVL] |
			(levels.rx_stat_used >
			 st.thresholds[hif_pkg::RX_STAT_LVL_LSB +: 8]);
		events[hif_pkg::SRC_RX_DMA_DONE] =
			src_events[hif_pkg::SRC_RX_DMA_DONE] | cnt_done;
	end

	// Countdown hits zero on the read that consumes its last word.
	assign cnt_done = rx_word_read & (st.countdown == 12'h001);

	// ------------------------------------------------------------
	// Padding words for the end alignment
	// ------------------------------------------------------------
	// The reserved code pads nothing, the safest reading for a bad value.
	always_comb begin
		case (hif_pkg::hif_align_e'(st.align))
			hif_pkg::HIF_ALIGN_4:  pad = 3'h0;
			hif_pkg::HIF_ALIGN_16: pad = 3'h3;
			hif_pkg::HIF_ALIGN_32: pad = 3'h7;
			default:               pad = 3'h0;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		wsel    = bus.wr ? 32'hFFFFFFFF : 32'h00000000;
		next_st.flush = 1'b0;

		// No write clears status, since the clear mask is all zero; new events are ORed in.
		next_st.status = (st.status & ~(bus.wdata & wsel &
			{32{bus.addr == hif_pkg::ADDR_INTERRUPT_MASK}} &
			32'h00000000)) | events;

		if (bus.wr) begin
			case (bus.addr)
				hif_pkg::ADDR_INTERRUPT_MASK: begin
					next_st.mask = bus.wdata &
						hif_pkg::INTERRUPT_MASK_WMSK;
				end
				hif_pkg::ADDR_FIFO_THRESHOLDS: begin
					next_st.thresholds = bus.wdata;
				end
				hif_pkg::ADDR_RECEIVE_CONFIG: begin
					next_st.align = bus.wdata[hif_pkg::ALIGN_LSB +: 2];
					next_st.offset = bus.wdata[hif_pkg::OFFSET_LSB +: 5];
					next_st.flush = bus.wdata[hif_pkg::FLUSH_BIT];
				end
				default: begin
				end
			endcase
		end

		// Host may reload the countdown at any time; its write wins over a read.
		if (bus.wr && bus.addr == hif_pkg::ADDR_RECEIVE_CONFIG) begin
			next_st.countdown = bus.wdata[hif_pkg::COUNTDOWN_LSB +: 12];
		end else if (rx_word_read && st.countdown != 12'h000) begin
			next_st.countdown = st.countdown - 12'h001;
		end

		// Word offset latches on a word read so a running packet sees it
		// only from the next word onward.
		if (rx_word_read || rx_packet_end) begin
			next_st.word_offset = st.offset[4:2];
		end

		// Read data is registered.
		case (bus.addr)
			hif_pkg::ADDR_INTERRUPT_MASK:   next_st.rdata = st.mask;
			hif_pkg::ADDR_BYTE_ORDER_PROBE:
				next_st.rdata = hif_pkg::BYTE_ORDER_PATTERN;
			hif_pkg::ADDR_FIFO_THRESHOLDS:  next_st.rdata = st.thresholds;
			hif_pkg::ADDR_RECEIVE_CONFIG: begin
				next_st.rdata = {st.align, 2'h0, st.countdown, 1'b0, 2'h0,
					st.offset, 8'h00};
			end
			default:                        next_st.rdata = 32'h00000000;
		endcase
		if (!bus.rd) begin
			next_st.rdata = st.rdata;
		end

		next_st.irq = |(next_st.status & next_st.mask);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st            <= '0;
			st.mask       <= hif_pkg::INTERRUPT_MASK_RST;
			st.thresholds <= hif_pkg::FIFO_THRESHOLDS_RST;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign rdata        = st.rdata;
	assign irq          = st.irq;
	assign rx_flush     = st.flush;
	assign rx_align     = st.align;
	assign rx_offset    = {st.word_offset, st.offset[1:0]};
	assign rx_pad_words = pad;
	assign status       = st.status;

endmodule : hif_regs

`default_nettype wire

// File: verif/hif_regs_monitor.sv
// Checker of the host configuration bank, watching its ports only.
`timescale 1ns/1ps
`default_nettype none
module hif_regs_monitor (
	// Clock and reset
	input wire logic                 mclk,
	input wire logic                 resetn,
	// Host side
	input wire hif_pkg::hif_bus_s    bus,
	input wire logic [31:0]          rdata,
	input wire logic                 irq,
	input wire logic [31:0]          status,
	// Sources and receive side
	input wire logic [31:0]          src_events,
	input wire hif_pkg::hif_levels_s levels,
	input wire logic                 rx_word_read,
	input wire logic                 rx_flush,
	input wire logic [1:0]           rx_align,
	input wire logic [4:0]           rx_offset
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	logic [31:0] msk;
	logic [31:0] thr;
	logic        hit;
	logic        w6c;
	logic [4:0]  off;
	// Shadows follow host writes, since mask and thresholds are not on the ports.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			msk <= 32'h0;
			thr <= hif_pkg::FIFO_THRESHOLDS_RST;
		end else if (bus.wr && bus.addr == hif_pkg::ADDR_INTERRUPT_MASK) begin
			msk <= bus.wdata & hif_pkg::INTERRUPT_MASK_WMSK;
		end else if (bus.wr && bus.addr == hif_pkg::ADDR_FIFO_THRESHOLDS) begin
			thr <= bus.wdata;
		end
	end
	// Two stable cycles are required, so either irq pipeline depth passes.
	assign hit = |(status & msk);
	assign w6c = bus.wr && bus.addr == hif_pkg::ADDR_RECEIVE_CONFIG;
	// Offset shadow; the word part reaches the port only on a word read or a packet end.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			off <= 5'h00;
		end else if (w6c) begin
			off <= bus.wdata[12:8];
		end
	end
	probe_read_a: assert property (
		bus.rd && bus.addr == hif_pkg::ADDR_BYTE_ORDER_PROBE
		|=> rdata == hif_pkg::BYTE_ORDER_PATTERN) else $error("probe value");
	mask_readback_a: assert property (
		bus.rd && bus.addr == hif_pkg::ADDR_INTERRUPT_MASK
		|=> rdata == $past(msk)) else $error("mask readback");
	irq_raise_a: assert property (hit && $past(hit) |-> irq)
		else $error("irq missing");
	irq_drop_a: assert property (!hit && !$past(hit) |-> !irq)
		else $error("irq stuck");
	event_record_a: assert property (
		src_events[31] |-> ##[1:2] status[31]) else $error("event lost");
	tx_space_a: assert property (
		levels.tx_space > thr[31:24] |-> ##[1:3] status[9])
		else $error("space event lost");
	flush_pulse_a: assert property (
		w6c && bus.wdata[15] |=> rx_flush ##1 !rx_flush)
		else $error("flush pulse");
	align_offset_a: assert property (
		w6c |=> rx_align == $past(bus.wdata[31:30])
		&& rx_offset[1:0] == $past(bus.wdata[9:8])) else $error("rx fields");
	word_offset_a: assert property (
		rx_word_read |=> rx_offset[4:2] == $past(off[4:2]))
		else $error("word offset");
endmodule : hif_regs_monitor
bind hif_regs hif_regs_monitor u_mon (.mclk(mclk), .resetn(resetn),
	.bus(bus), .rdata(rdata), .irq(irq), .status(status),
	.src_events(src_events), .levels(levels),
	.rx_word_read(rx_word_read), .rx_flush(rx_flush),
	.rx_align(rx_align), .rx_offset(rx_offset));
`default_nettype wire

// File: verif/hif_host_model.sv
// Host processor model that makes register cycles on the bank's bus.
`timescale 1ns/1ps
`default_nettype none
module hif_host_model (
	// Clock
	input wire logic               mclk,
	// Register bus
	output var hif_pkg::hif_bus_s  bus,
	input wire logic [31:0]        rdata
);
	initial bus = '0;
	// Released lines show the inverse, so a stale value never looks valid.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk) #1;
		bus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge mclk) #1;
		bus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask : wr
	// No packet data is read here, so no padding is left to drop.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk) #1;
		bus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
		@(posedge mclk) #1;
		bus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 32'hFFFFFFFF};
		d = rdata;
	endtask : rd
endmodule : hif_host_model
`default_nettype wire

// File: verif/hif_regs_test.sv
// Self-checking testbench of the host configuration bank.
`timescale 1ns/1ps
`default_nettype none
module hif_regs_test;
	localparam logic [7:0] PRB = hif_pkg::ADDR_BYTE_ORDER_PROBE;
	localparam logic [7:0] MSK = hif_pkg::ADDR_INTERRUPT_MASK;
	localparam logic [7:0] THR = hif_pkg::ADDR_FIFO_THRESHOLDS;
	localparam logic [7:0] CFG = hif_pkg::ADDR_RECEIVE_CONFIG;
	logic mclk, resetn, irq, rx_word_read, rx_packet_end, rx_flush;
	logic [31:0] rdata, src_events, status, d;
	logic [1:0] rx_align;
	logic [4:0] rx_offset;
	logic [2:0] rx_pad_words;
	hif_pkg::hif_bus_s    bus;
	hif_pkg::hif_levels_s levels;
	int err_total;
	int checked;
	hif_host_model u_host (.mclk(mclk), .bus(bus), .rdata(rdata));
	hif_regs u_dut (.mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata),
		.irq(irq), .src_events(src_events), .levels(levels),
		.rx_word_read(rx_word_read), .rx_packet_end(rx_packet_end),
		.rx_flush(rx_flush), .rx_align(rx_align), .rx_offset(rx_offset),
		.rx_pad_words(rx_pad_words), .status(status));
	always #4 mclk = ~mclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		u_host.rd(a, d);
		check(d, e);
	endtask : rc
	// One data word leaves the receive FIFO per pulse.
	task automatic word();
		@(posedge mclk) #1 rx_word_read = 1'b1;
		@(posedge mclk) #1 rx_word_read = 1'b0;
	endtask : word
	task automatic finish_test();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test
	// A hang is cut short and counted as a failure.
	initial begin
		repeat (3000) @(posedge mclk);
		err_total++;
		finish_test();
	end
	initial begin
		{mclk, resetn, rx_word_read, rx_packet_end, src_events} = '0;
		levels = '{8'h00, 8'h00, 8'hFF, 8'h00};
		repeat (3) @(posedge mclk);
		#1 resetn = 1'b1;
		rc(PRB, 32'h87654321);
		u_host.wr(PRB, 32'h0);
		rc(PRB, 32'h87654321);
		rc(MSK, 32'h0);
		rc(THR, 32'h48000000);
		rc(8'h00, 32'h0);
		u_host.wr(MSK, 32'hFFFFFFFF);
		rc(MSK, 32'h83BFEFFF);
		u_host.wr(MSK, 32'h0);
		@(posedge mclk) #1 src_events = 32'h80000000;
		@(posedge mclk) #1 src_events = 32'h0;
		repeat (3) @(posedge mclk);
		check(status[31], 1'b1);
		check(irq, 1'b0);
		u_host.wr(MSK, 32'h80000000);
		repeat (2) @(posedge mclk);
		check(irq, 1'b1);
		u_host.wr(MSK, 32'h0);
		repeat (2) @(posedge mclk);
		check(irq, 1'b0);
		u_host.wr(THR, 32'h48001000);
		levels = '{8'h48, 8'h00, 8'h10, 8'h00};
		repeat (4) @(posedge mclk);
		check(status & 32'h2A8, 32'h0);
		levels = '{8'h49, 8'h01, 8'h0F, 8'h01};
		repeat (4) @(posedge mclk);
		check(status & 32'h2A8, 32'h2A8);
		u_host.wr(CFG, 32'h00030000);
		word();
		word();
		check(status[20], 1'b0);
		word();
		repeat (3) @(posedge mclk);
		check(status[20], 1'b1);
		for (int i = 0; i < 4; i++) begin
			u_host.wr(CFG, {2'(i), 17'h0, 5'(31 - i), 8'h0});
			check(32'(rx_align), 32'(i));
			check(32'(rx_pad_words), (i == 1) ? 3 : (i == 2) ? 7 : 0);
			word();
			check(32'(rx_offset), 32'(31 - i));
		end
		u_host.wr(CFG, 32'h00008000);
		check(rx_flush, 1'b1);
		@(posedge mclk) #1;
		check(rx_flush, 1'b0);
		resetn = 1'b0;
		repeat (2) @(posedge mclk);
		#1 resetn = 1'b1;
		rc(THR, 32'h48000000);
		rc(MSK, 32'h0);
		finish_test();
	end
endmodule : hif_regs_test
`default_nettype wire
